/* File: src/gdrc_defines.vh */
// What this block does
// - direction bit 0 makes a pin input, 1 makes it output
// - upper config at 630h: pin n select bit 2*(n-16), direction next bit
// - upper input with select 0 feeds upper input data bit n-16
// - input with select 1 feeds the general interrupt path
// - upper output with select 0 is driven from upper output data bit n-16
// - pin 15 uses lower bits 30/31; output select 1 drives hot-plug reset
// - upper config register exists only in upstream port space
// - all bits reset to 0; writable by software, loader and serial bus
`ifndef GDRC_DEFINES_VH
`define GDRC_DEFINES_VH
`define GDRC_OFF_LOWER    12'h62C
`define GDRC_OFF_UPPER    12'h630
`define GDRC_OFF_IN_LO    12'h63C
`define GDRC_OFF_IN_HI    12'h640
`define GDRC_OFF_OUT_LO   12'h644
`define GDRC_OFF_OUT_HI   12'h648
`define GDRC_CFG_RESET    32'h00000000
`define GDRC_P15_SEL_BIT  30
`define GDRC_P15_DIR_BIT  31
`define GDRC_NUM_UPPER    16
`endif

/* File: src/gdrc_pin_route.v */
`timescale 1ns/1ps
// routing of one pin from its select and direction bits
module gdrc_pin_route (
  input  wire sel,
  input  wire dir,
  input  wire pin_in,
  input  wire out_data,
  input  wire alt_out,
  output wire in_data,
  output wire irq_src,
  output wire pin_out,
  output wire pin_oe_n
);
  assign pin_oe_n = ~dir;
  assign in_data  = ~dir & ~sel & pin_in;
  assign irq_src  = ~dir & sel & pin_in;
  assign pin_out  = dir & (sel ? alt_out : out_data);
endmodule // gdrc_pin_route

/* File: src/gdrc_cfg.v */
`timescale 1ns/1ps
`include "gdrc_defines.vh"
module gdrc_cfg (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        upstream_port,
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [11:0] cfg_addr,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  output reg  [31:0] cfg_rdata,
  input  wire [16:0] gpio_in,
  input  wire [16:0] out_data,
  input  wire        hp_perst_in,
  output wire [16:0] gpio_out,
  output wire [16:0] gpio_oe_n,
  output reg  [16:0] in_data_ff,
  output reg  [16:0] irq_src_ff,
  output reg  [15:0] upper_sel_err_ff
);
  // bit 0 = pin 15, bits 16:1 = pins 16..31
  reg  [31:0] lower_pin_config_tail_ff;
  reg  [31:0] upper_pin_direction_select_ff;
  reg  [31:0] nxt_lower_pin_config_tail;
  reg  [31:0] nxt_upper_pin_direction_select;
  reg  [16:0] nxt_in_data;
  reg  [16:0] nxt_irq_src;
  reg  [15:0] nxt_upper_sel_err;
  reg  [31:0] nxt_cfg_rdata;
  wire [16:0] sel_v;
  wire [16:0] dir_v;
  wire [16:0] alt_v;
  wire [16:0] in_w;
  wire [16:0] irq_w;
  wire        hit_lo;
  wire        hit_hi;
  wire        wr_lo;
  wire        wr_hi;
  genvar      i;

  // address decode
  assign hit_lo = (cfg_addr == `GDRC_OFF_LOWER);
  // the upper register exists only in the upstream port
  assign hit_hi = (cfg_addr == `GDRC_OFF_UPPER) & upstream_port;
  assign wr_lo  = cfg_wr & hit_lo;
  assign wr_hi  = cfg_wr & hit_hi;

  // lower register: whole word kept, only the pin 15 pair is used
  always @* begin
    nxt_lower_pin_config_tail = lower_pin_config_tail_ff;
    if (wr_lo & cfg_be[0]) begin
      nxt_lower_pin_config_tail[7:0] = cfg_wdata[7:0];
    end
    if (wr_lo & cfg_be[1]) begin
      nxt_lower_pin_config_tail[15:8] = cfg_wdata[15:8];
    end
    if (wr_lo & cfg_be[2]) begin
      nxt_lower_pin_config_tail[23:16] = cfg_wdata[23:16];
    end
    if (wr_lo & cfg_be[3]) begin
      nxt_lower_pin_config_tail[31:24] = cfg_wdata[31:24];
    end
  end

  // upper register: one byte lane per enable
  always @* begin
    nxt_upper_pin_direction_select = upper_pin_direction_select_ff;
    if (wr_hi & cfg_be[0]) begin
      nxt_upper_pin_direction_select[7:0] = cfg_wdata[7:0];
    end
    if (wr_hi & cfg_be[1]) begin
      nxt_upper_pin_direction_select[15:8] = cfg_wdata[15:8];
    end
    if (wr_hi & cfg_be[2]) begin
      nxt_upper_pin_direction_select[23:16] = cfg_wdata[23:16];
    end
    if (wr_hi & cfg_be[3]) begin
      nxt_upper_pin_direction_select[31:24] = cfg_wdata[31:24];
    end
  end

  // routing follows the register on the clock after the write
  always @(posedge clk_sys) begin
    if (!rstn) begin
      lower_pin_config_tail_ff      <= `GDRC_CFG_RESET;
      upper_pin_direction_select_ff <= `GDRC_CFG_RESET;
    end else begin
      lower_pin_config_tail_ff      <= nxt_lower_pin_config_tail;
      upper_pin_direction_select_ff <= nxt_upper_pin_direction_select;
    end
  end

  // pin 15 pair
  assign sel_v[0]  = lower_pin_config_tail_ff[`GDRC_P15_SEL_BIT];
  assign dir_v[0]  = lower_pin_config_tail_ff[`GDRC_P15_DIR_BIT];

  // pins 16..31: select at even bit, direction at the odd bit above
  assign sel_v[1]  = upper_pin_direction_select_ff[0];
  assign dir_v[1]  = upper_pin_direction_select_ff[1];
  assign sel_v[2]  = upper_pin_direction_select_ff[2];
  assign dir_v[2]  = upper_pin_direction_select_ff[3];
  assign sel_v[3]  = upper_pin_direction_select_ff[4];
  assign dir_v[3]  = upper_pin_direction_select_ff[5];
  assign sel_v[4]  = upper_pin_direction_select_ff[6];
  assign dir_v[4]  = upper_pin_direction_select_ff[7];
  assign sel_v[5]  = upper_pin_direction_select_ff[8];
  assign dir_v[5]  = upper_pin_direction_select_ff[9];
  assign sel_v[6]  = upper_pin_direction_select_ff[10];
  assign dir_v[6]  = upper_pin_direction_select_ff[11];
  assign sel_v[7]  = upper_pin_direction_select_ff[12];
  assign dir_v[7]  = upper_pin_direction_select_ff[13];
  assign sel_v[8]  = upper_pin_direction_select_ff[14];
  assign dir_v[8]  = upper_pin_direction_select_ff[15];
  assign sel_v[9]  = upper_pin_direction_select_ff[16];
  assign dir_v[9]  = upper_pin_direction_select_ff[17];
  assign sel_v[10] = upper_pin_direction_select_ff[18];
  assign dir_v[10] = upper_pin_direction_select_ff[19];
  assign sel_v[11] = upper_pin_direction_select_ff[20];
  assign dir_v[11] = upper_pin_direction_select_ff[21];
  assign sel_v[12] = upper_pin_direction_select_ff[22];
  assign dir_v[12] = upper_pin_direction_select_ff[23];
  assign sel_v[13] = upper_pin_direction_select_ff[24];
  assign dir_v[13] = upper_pin_direction_select_ff[25];
  assign sel_v[14] = upper_pin_direction_select_ff[26];
  assign dir_v[14] = upper_pin_direction_select_ff[27];
  assign sel_v[15] = upper_pin_direction_select_ff[28];
  assign dir_v[15] = upper_pin_direction_select_ff[29];
  assign sel_v[16] = upper_pin_direction_select_ff[30];
  assign dir_v[16] = upper_pin_direction_select_ff[31];

  // only pin 15 has an alternate output; reserved upper pins drive 0
  assign alt_v[0]    = hp_perst_in;
  assign alt_v[16:1] = 16'h0000;

  generate
    for (i = 0; i < 17; i = i + 1) begin : g_pin
      gdrc_pin_route u_route (
        .sel      (sel_v[i]),
        .dir      (dir_v[i]),
        .pin_in   (gpio_in[i]),
        .out_data (out_data[i]),
        .alt_out  (alt_v[i]),
        .in_data  (in_w[i]),
        .irq_src  (irq_w[i]),
        .pin_out  (gpio_out[i]),
        .pin_oe_n (gpio_oe_n[i])
      );
    end
  endgenerate

  // sampled pin views and the reserved-combination flag
  always @* begin
    nxt_in_data       = in_w;
    nxt_irq_src       = irq_w;
    // select 1 while output is reserved on the upper pins
    nxt_upper_sel_err = sel_v[16:1] & dir_v[16:1];
  end

  // read data holds until the next read
  always @* begin
    nxt_cfg_rdata = cfg_rdata;
    if (cfg_rd) begin
      case (cfg_addr)
        `GDRC_OFF_LOWER: begin
          nxt_cfg_rdata = lower_pin_config_tail_ff;
        end
        `GDRC_OFF_UPPER: begin
          // a downstream port has no upper register and reads zero
          if (upstream_port) begin
            nxt_cfg_rdata = upper_pin_direction_select_ff;
          end else begin
            nxt_cfg_rdata = 32'h00000000;
          end
        end
        default: begin
          nxt_cfg_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      in_data_ff       <= 17'h00000;
      irq_src_ff       <= 17'h00000;
      upper_sel_err_ff <= 16'h0000;
      cfg_rdata        <= 32'h00000000;
    end else begin
      in_data_ff       <= nxt_in_data;
      irq_src_ff       <= nxt_irq_src;
      upper_sel_err_ff <= nxt_upper_sel_err;
      cfg_rdata        <= nxt_cfg_rdata;
    end
  end
endmodule // gdrc_cfg

/* File: verification/gdrc_cfg_assertions.sv */
`timescale 1ns/1ps
module gdrc_chk (
  input wire clk_sys, rstn, upstream_port, cfg_wr, cfg_rd, hp_perst_in,
  input wire [11:0] cfg_addr,
  input wire [3:0]  cfg_be,
  input wire [31:0] cfg_wdata, cfg_rdata,
  input wire [16:0] gpio_in, out_data, gpio_out, gpio_oe_n, in_data_ff, irq_src_ff,
  input wire [15:0] upper_sel_err_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire up_wr = cfg_wr && cfg_addr == 12'h630 && upstream_port && cfg_be[0];
  wire lo_wr = cfg_wr && cfg_addr == 12'h62C && cfg_be[3];
  dir_pin_a: assert property (up_wr |=> gpio_oe_n[1] == !$past(cfg_wdata[1]))
    else $error("pin16 direction wrong");
  dir_p15_a: assert property (lo_wr |=> gpio_oe_n[0] == !$past(cfg_wdata[31]))
    else $error("pin15 direction wrong");
  in_route_a: assert property (up_wr && cfg_wdata[1:0] == 2'h0 |=> ##1
    in_data_ff[1] == $past(gpio_in[1])) else $error("input data not routed");
  irq_route_a: assert property (up_wr && cfg_wdata[1:0] == 2'h1 |=> ##1
    irq_src_ff[1] == $past(gpio_in[1])) else $error("interrupt source not routed");
  out_drive_a: assert property (up_wr && cfg_wdata[1:0] == 2'h2 |=>
    gpio_out[1] == out_data[1]) else $error("output data not driven");
  down_wr_a: assert property (cfg_wr && cfg_addr == 12'h630 && !upstream_port |=>
    $stable(gpio_oe_n)) else $error("write took effect off upstream");
  down_rd_a: assert property (cfg_rd && cfg_addr == 12'h630 && !upstream_port ##1 1
    |=> cfg_rdata == 32'h0) else $error("read not zero off upstream");
  reset_val_a: assert property ($rose(rstn) |-> &gpio_oe_n)
    else $error("pins not inputs after reset");
  rsvd_flag_a: assert property (up_wr && cfg_wdata[1:0] == 2'h3 |=> ##1
    upper_sel_err_ff[0]) else $error("reserved combination not flagged");
  rsvd_drive_a: assert property (up_wr && cfg_wdata[1:0] == 2'h3 |=>
    gpio_out[1] == 1'b0) else $error("reserved combination drives pin");
  cover property (up_wr && cfg_wdata[1:0] == 2'h3);
  cover property (up_wr);
  cover property (lo_wr && cfg_wdata[31:30] == 2'h3);
  cover property (cfg_rd && !upstream_port);
endmodule // gdrc_chk
bind gdrc_cfg gdrc_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .upstream_port(upstream_port),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .hp_perst_in(hp_perst_in), .cfg_addr(cfg_addr),
  .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .gpio_in(gpio_in),
  .out_data(out_data), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .in_data_ff(in_data_ff),
  .irq_src_ff(irq_src_ff), .upper_sel_err_ff(upper_sel_err_ff));

/* File: verification/gdrc_cfg_tb.sv */
`timescale 1ns/1ps
module gdrc_cfg_tb;
  reg         clk_sys = 0, rstn = 0, upstream_port = 1, cfg_wr = 0, cfg_rd = 0, hp_perst_in = 0;
  reg  [11:0] cfg_addr = 12'h000;
  reg  [3:0]  cfg_be = 4'hF;
  reg  [31:0] cfg_wdata = 32'h0;
  reg  [16:0] gpio_in = 17'h15A5B, out_data = 17'h0C3C3;
  wire [31:0] cfg_rdata;
  wire [16:0] gpio_out, gpio_oe_n, in_data_ff, irq_src_ff;
  wire [15:0] upper_sel_err_ff;
  integer     bad_count = 0, n_compared = 0, i;
  reg  [47:0] rows [0:2];
  always #20 clk_sys = ~clk_sys;
  gdrc_cfg dut (.clk_sys(clk_sys), .rstn(rstn), .upstream_port(upstream_port), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .gpio_in(gpio_in), .out_data(out_data), .hp_perst_in(hp_perst_in),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .in_data_ff(in_data_ff),
    .irq_src_ff(irq_src_ff), .upper_sel_err_ff(upper_sel_err_ff));
  task chk(input [31:0] seen, input [31:0] exp); begin
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end endtask
  task wr(input [11:0] a, input [31:0] d); begin
    @(posedge clk_sys); cfg_wr <= 1; cfg_addr <= a; cfg_wdata <= d;
    @(posedge clk_sys); cfg_wr <= 0; #1;
  end endtask
  task rd(input [11:0] a); begin
    @(posedge clk_sys); cfg_rd <= 1; cfg_addr <= a;
    @(posedge clk_sys); cfg_rd <= 0;
    @(posedge clk_sys); #1;
  end endtask
  task wrap_up; begin
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end endtask
  initial begin
    rows[0] = {16'hFFFE, 32'h00000002};
    rows[1] = {16'h7FFF, 32'h80000000};
    rows[2] = {16'h0000, 32'hAAAAAAAA};
    repeat (10) @(posedge clk_sys);
    rstn <= 1;
    rd(12'h630); chk(cfg_rdata, 32'h0); chk(gpio_oe_n, 17'h1FFFF);
    for (i = 0; i < 3; i = i + 1) begin
      wr(12'h630, rows[i][31:0]); chk(gpio_oe_n[16:1], rows[i][47:32]);
    end
    chk(gpio_out[16:1], out_data[16:1]);
    rd(12'h630); chk(cfg_rdata, 32'hAAAAAAAA);
    wr(12'h630, 32'h55555555); repeat (2) @(posedge clk_sys); #1;
    chk(irq_src_ff[16:1], gpio_in[16:1]); chk(in_data_ff[16:1], 16'h0);
    wr(12'h630, 32'h0); repeat (2) @(posedge clk_sys); #1;
    chk(in_data_ff[16:1], gpio_in[16:1]);
    @(posedge clk_sys); upstream_port <= 0;
    wr(12'h630, 32'hAAAAAAAA); chk(gpio_oe_n[16:1], 16'hFFFF);
    rd(12'h630); chk(cfg_rdata, 32'h0);
    @(posedge clk_sys); upstream_port <= 1; hp_perst_in <= 1;
    wr(12'h62C, 32'hC0000000);
    chk(gpio_out[0], 1'b1); chk(gpio_oe_n[0], 1'b0);
    @(posedge clk_sys); hp_perst_in <= 0; #1;
    chk(gpio_out[0], 1'b0);
    rd(12'h62C); chk(cfg_rdata, 32'hC0000000);
    wr(12'h62C, 32'h80000000); chk(gpio_out[0], out_data[0]);
    wr(12'h62C, 32'h40000000); repeat (2) @(posedge clk_sys); #1;
    chk(irq_src_ff[0], gpio_in[0]); chk(in_data_ff[0], 1'b0);
    wr(12'h62C, 32'h00000000); repeat (2) @(posedge clk_sys); #1;
    chk(in_data_ff[0], gpio_in[0]); chk(irq_src_ff[0], 1'b0);
    wr(12'h630, 32'h00000003); repeat (2) @(posedge clk_sys); #1;
    chk(upper_sel_err_ff, 16'h0001); chk(gpio_out[1], 1'b0);
    @(posedge clk_sys); cfg_be <= 4'h8;
    wr(12'h630, 32'hAAFFFFFF); rd(12'h630); chk(cfg_rdata, 32'hAA000003);
    @(posedge clk_sys); cfg_be <= 4'hF;
    @(posedge clk_sys); rstn <= 0; repeat (2) @(posedge clk_sys); rstn <= 1; #1;
    chk(gpio_oe_n, 17'h1FFFF); chk(upper_sel_err_ff, 16'h0);
    chk(cfg_rdata, 32'h0); chk(gpio_out, 17'h0);
    wrap_up;
  end
endmodule // gdrc_cfg_tb
